// *** design/ptm_timer.sv ***
// Notes on behaviour
// R1: ten-bit up-counter compared with duty, period
// R2: counter zeroed on enable rise, held when off
// R3: compare mode duty match applies output action
// R4: pwm mode action: inactive, active, pwm, pulse
// R5: capture mode action selects capture edge
// R6: capture source: output pin or clock pin
// R7: compare mode enable rise restores initial level
// R8: software picks action level unlike initial level
// R9: software changes action only while stopped
// R10: initial bit: start level or active level
// R11: polarity bit inverts pin, not timer mode
// R12: clear select: duty match, else period/overflow
// R13: overflow clear only with period zero
// R14: clear select ignored in pwm, pulse, capture
// R15: mode 00 compare, mode 11 timer
// R16: software selects pwm with mode and action 10
// R17: clear select one suppresses period flag
// R18: software never sets compare duty zero
// R19: only duty match changes compare-mode pin; the code also sets it to the initial level on enable rise
// R20: timer mode like compare, pin undriven
// R21: pwm period from period value, zero 1024
// R22: duty at or above period gives full duty
// R23: pwm raises duty and period flags
// R24: pwm counting continues while pin forced
// R25: pwm active below duty, then polarity
// R26: flags set with the clearing or pin edge; pwm and pulse set the duty flag one clock before the pin edge
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ptm_timer
    import ptm_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // axi4-lite write
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [PTM_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // axi4-lite read
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [PTM_AW-1:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // pins
    input wire logic timer_output_pin_in,
    output logic timer_output_pin_out,
    output logic timer_output_pin_oe_out,
    input wire logic timer_clock_pin_in,
    // status toward the rest of the timer
    output logic duty_match_flag_out,
    output logic period_match_flag_out,
    output logic counter_on_out
);
    function automatic logic addr_hit(input logic [PTM_AW-1:0] a, input logic [7:0] ofs);
        addr_hit = (a[PTM_AW-1:2] == ofs[PTM_AW-1:2]);
    endfunction : addr_hit

    function automatic logic [9:0] wr10(input logic [9:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
        wr10 = {s[1] ? d[9:8] : old[9:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : wr10

    logic [1:0] rst_sync_reg;
    logic rst_n;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    // registers
    ptm_ctrl_t ctrl_reg;
    logic on_reg;
    logic on_prev_reg;
    logic [9:0] count_reg;
    logic [9:0] duty_reg;
    logic [9:0] period_reg;
    logic dflag_reg;
    logic pflag_reg;
    logic lvl_reg;
    logic pin_out_reg;
    logic pin_oe_reg;

    // pins: a change counts once stages two and three agree
    logic [2:0] tp_sync_reg;
    logic [2:0] tck_sync_reg;
    logic tp_stable_reg;
    logic tck_stable_reg;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tp_sync_reg <= 3'h0;
            tck_sync_reg <= 3'h0;
            tp_stable_reg <= 1'b0;
            tck_stable_reg <= 1'b0;
        end else begin
            tp_sync_reg <= {tp_sync_reg[1:0], timer_output_pin_in};
            tck_sync_reg <= {tck_sync_reg[1:0], timer_clock_pin_in};
            if (tp_sync_reg[1] == tp_sync_reg[2]) begin
                tp_stable_reg <= tp_sync_reg[2];
            end
            if (tck_sync_reg[1] == tck_sync_reg[2]) begin
                tck_stable_reg <= tck_sync_reg[2];
            end
        end
    end
    logic tp_new;
    logic tck_new;
    assign tp_new = (tp_sync_reg[1] == tp_sync_reg[2]) ? tp_sync_reg[2] : tp_stable_reg;
    assign tck_new = (tck_sync_reg[1] == tck_sync_reg[2]) ? tck_sync_reg[2] : tck_stable_reg;

    logic cap_in_old;
    logic cap_in_new;
    logic cap_rise;
    logic cap_fall;
    logic cap_event;
    logic tck_rise;
    assign cap_in_old = ctrl_reg.capture_source_bit ? tck_stable_reg : tp_stable_reg; // [R6]
    assign cap_in_new = ctrl_reg.capture_source_bit ? tck_new : tp_new; // [R6]
    assign cap_rise = cap_in_new & ~cap_in_old;
    assign cap_fall = ~cap_in_new & cap_in_old;
    assign tck_rise = tck_new & ~tck_stable_reg;

    // mode decode
    logic m_cmp;
    logic m_cmp_like;
    logic m_pwm;
    logic m_sp;
    logic m_cap;
    logic on_rise;
    logic run;
    logic dm;
    logic pm;
    logic clr;
    logic dset;
    logic pset;
    assign m_cmp = (ctrl_reg.mode_select == PTM_MODE_CMP); // [R15]
    assign m_cmp_like = m_cmp | (ctrl_reg.mode_select == PTM_MODE_TMR); // [R15] [R20]
    assign m_cap = (ctrl_reg.mode_select == PTM_MODE_CAP);
    assign m_pwm = (ctrl_reg.mode_select == PTM_MODE_PWM) &&
                   (ctrl_reg.output_action != PTM_IO_11);
    assign m_sp = (ctrl_reg.mode_select == PTM_MODE_PWM) &&
                  (ctrl_reg.output_action == PTM_IO_11);
    assign on_rise = on_reg & ~on_prev_reg;
    assign run = on_reg & ~on_rise;
    // match fires one count early; period zero
    // matches at 1023, the overflow clear
    assign dm = (count_reg == duty_reg - 10'h001); // [R1]
    assign pm = (count_reg == period_reg - 10'h001); // [R1] [R13] [R21]

    always_comb begin
        clr = 1'b0;
        if (m_cmp_like) begin
            clr = ctrl_reg.clear_select_bit ? dm : pm; // [R12] [R13]
        end else if (m_pwm || m_cap) begin
            clr = pm; // [R14] [R21] [R24]
        end
    end

    always_comb begin
        cap_event = 1'b0;
        if (m_cap && on_reg) begin
            case (ctrl_reg.output_action) // [R5]
                PTM_IO_00: cap_event = cap_rise;
                PTM_IO_01: cap_event = cap_fall;
                PTM_IO_10: cap_event = cap_rise | cap_fall;
                default: cap_event = 1'b0;
            endcase
        end
    end

    assign dset = (run & dm & ~m_cap) | cap_event; // [R23] [R26]
    assign pset = run & pm & ~m_sp & ~(m_cmp_like & ctrl_reg.clear_select_bit); // [R17] [R23]

    // counter
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 10'h000;
            on_prev_reg <= 1'b0;
        end else begin
            on_prev_reg <= on_reg;
            if (on_rise) begin
                count_reg <= 10'h000; // [R2]
            end else if (!on_reg || (m_sp && dm)) begin
                count_reg <= count_reg; // [R2]
            end else if (clr) begin
                count_reg <= 10'h000; // [R12] [R21]
            end else begin
                count_reg <= count_reg + 10'h001; // [R1]
            end
        end
    end

    // output level before polarity
    logic lvl_next;
    logic act;
    logic [9:0] pwm_cnt;
    assign act = ctrl_reg.initial_level_bit; // [R10]
    // an enable rise starts the period from zero, not from the held count
    assign pwm_cnt = on_rise ? 10'h000 : count_reg;
    always_comb begin
        lvl_next = lvl_reg;
        if (m_cmp) begin
            if (on_rise) begin
                lvl_next = act; // [R7] [R10]
            end else if (run && dm) begin
                case (ctrl_reg.output_action) // [R3] [R19]
                    PTM_IO_01: lvl_next = 1'b0;
                    PTM_IO_10: lvl_next = 1'b1;
                    PTM_IO_11: lvl_next = ~lvl_reg;
                    default: lvl_next = lvl_reg;
                endcase
            end
        end else if (ctrl_reg.mode_select == PTM_MODE_PWM) begin
            case (ctrl_reg.output_action) // [R4] [R24]
                PTM_IO_00: lvl_next = ~act;
                PTM_IO_01: lvl_next = act;
                PTM_IO_10: lvl_next = (pwm_cnt < duty_reg) ? act : ~act; // [R22] [R25]
                default: lvl_next = on_reg ? act : ~act;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            lvl_reg <= 1'b0;
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else begin
            lvl_reg <= lvl_next;
            pin_out_reg <= lvl_next ^ ctrl_reg.polarity_invert_bit; // [R11] [R25]
            pin_oe_reg <= m_cmp | (ctrl_reg.mode_select == PTM_MODE_PWM); // [R20]
        end
    end

    // axi4-lite slave
    logic aw_held_reg;
    logic w_held_reg;
    logic [PTM_AW-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic wr_go;
    logic [PTM_AW-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic wr_known;
    assign s_axi_awready_out = ~aw_held_reg;
    assign s_axi_wready_out = ~w_held_reg;
    assign wa = aw_held_reg ? awaddr_reg : s_axi_awaddr_in;
    assign wd = w_held_reg ? wdata_reg : s_axi_wdata_in;
    assign ws = w_held_reg ? wstrb_reg : s_axi_wstrb_in;
    assign wr_go = ~bvalid_reg & (aw_held_reg | s_axi_awvalid_in) & (w_held_reg | s_axi_wvalid_in);
    assign wr_known = addr_hit(wa, PTM_OFS_CTRL0) | addr_hit(wa, PTM_OFS_CTRL1) |
                      addr_hit(wa, PTM_OFS_COUNT) | addr_hit(wa, PTM_OFS_DUTY) |
                      addr_hit(wa, PTM_OFS_PERIOD) | addr_hit(wa, PTM_OFS_FLAGS);

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= PTM_RESP_OKAY;
        end else begin
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? PTM_RESP_OKAY : PTM_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid_in && !aw_held_reg) begin
                    aw_held_reg <= 1'b1;
                    awaddr_reg <= s_axi_awaddr_in;
                end
                if (s_axi_wvalid_in && !w_held_reg) begin
                    w_held_reg <= 1'b1;
                    wdata_reg <= s_axi_wdata_in;
                    wstrb_reg <= s_axi_wstrb_in;
                end
                if (bvalid_reg && s_axi_bready_in) begin
                    bvalid_reg <= 1'b0;
                end
            end
        end
    end

    // hardware events beat same-cycle writes
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= PTM_RST_CTRL1;
            on_reg <= 1'b0;
            duty_reg <= PTM_RST_CMP;
            period_reg <= PTM_RST_CMP;
        end else begin
            if (wr_go && ws[0] && addr_hit(wa, PTM_OFS_CTRL1)) begin
                ctrl_reg <= wd[7:0];
            end
            if (wr_go && addr_hit(wa, PTM_OFS_PERIOD)) begin
                period_reg <= wr10(period_reg, wd, ws);
            end
            if (cap_event) begin
                duty_reg <= count_reg; // [R5]
            end else if (wr_go && addr_hit(wa, PTM_OFS_DUTY)) begin
                duty_reg <= wr10(duty_reg, wd, ws);
            end
            // the pulse ends on a duty match; the clock pin can start it
            if (m_sp && run && dm) begin
                on_reg <= 1'b0; // [R4]
            end else if (m_sp && !on_reg && tck_rise) begin
                on_reg <= 1'b1; // [R4]
            end else if (wr_go && ws[0] && addr_hit(wa, PTM_OFS_CTRL0)) begin
                on_reg <= wd[PTM_POS_ON];
            end
        end
    end

    // match flags: write one to clear, a same-cycle set wins
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            dflag_reg <= 1'b0;
            pflag_reg <= 1'b0;
        end else begin
            if (dset) begin
                dflag_reg <= 1'b1; // [R26]
            end else if (wr_go && ws[0] && addr_hit(wa, PTM_OFS_FLAGS) && wd[PTM_POS_DUTY_FLAG]) begin
                dflag_reg <= 1'b0;
            end
            if (pset) begin
                pflag_reg <= 1'b1; // [R26]
            end else if (wr_go && ws[0] && addr_hit(wa, PTM_OFS_FLAGS) &&
                         wd[PTM_POS_PERIOD_FLAG]) begin
                pflag_reg <= 1'b0;
            end
        end
    end

    logic [31:0] rd_mux;
    logic rd_known;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_known = 1'b1;
        if (addr_hit(s_axi_araddr_in, PTM_OFS_CTRL0)) begin
            rd_mux[PTM_POS_ON] = on_reg;
        end else if (addr_hit(s_axi_araddr_in, PTM_OFS_CTRL1)) begin
            rd_mux[7:0] = ctrl_reg;
        end else if (addr_hit(s_axi_araddr_in, PTM_OFS_COUNT)) begin
            rd_mux[9:0] = count_reg;
        end else if (addr_hit(s_axi_araddr_in, PTM_OFS_DUTY)) begin
            rd_mux[9:0] = duty_reg;
        end else if (addr_hit(s_axi_araddr_in, PTM_OFS_PERIOD)) begin
            rd_mux[9:0] = period_reg;
        end else if (addr_hit(s_axi_araddr_in, PTM_OFS_FLAGS)) begin
            rd_mux[PTM_POS_DUTY_FLAG] = dflag_reg;
            rd_mux[PTM_POS_PERIOD_FLAG] = pflag_reg;
        end else begin
            rd_known = 1'b0;
        end
    end

    assign s_axi_arready_out = ~rvalid_reg;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= PTM_RESP_OKAY;
        end else if (s_axi_arvalid_in && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_known ? PTM_RESP_OKAY : PTM_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out = rdata_reg;
    assign s_axi_rresp_out = rresp_reg;
    assign timer_output_pin_out = pin_out_reg;
    assign timer_output_pin_oe_out = pin_oe_reg;
    assign duty_match_flag_out = dflag_reg;
    assign period_match_flag_out = pflag_reg;
    assign counter_on_out = on_reg;

    a_on_rise_clear: assert property (on_rise |=> count_reg == 10'h000) // [R2]
        else $error("counter not zeroed after enable rise");
    a_off_hold: assert property (!on_reg && !on_prev_reg |=> $stable(count_reg)) // [R2]
        else $error("counter moved while off");
    a_cmp_init: assert property (m_cmp && on_rise |=> lvl_reg == $past(act)) // [R7]
        else $error("initial level not restored");
    a_cmp_toggle: assert property (m_cmp && run && dm && ctrl_reg.output_action == PTM_IO_11
        |=> lvl_reg != $past(lvl_reg)) // [R3]
        else $error("toggle action missing");
    a_timer_no_drive: assert property (ctrl_reg.mode_select == PTM_MODE_TMR |=> !pin_oe_reg) // [R20]
        else $error("pin driven in timer mode");
    a_cclr_no_pflag: assert property (m_cmp_like && ctrl_reg.clear_select_bit
        |=> !(pflag_reg && !$past(pflag_reg))) // [R17]
        else $error("period flag with clear select");
    a_duty_flag_set: assert property (run && dm && !m_cap |=> dflag_reg) // [R26]
        else $error("duty flag not set on match");
    a_pwm_clear: assert property (m_pwm && run && pm ##1 m_pwm |-> count_reg == 10'h000) // [R21]
        else $error("pwm counter not cleared at period");
    a_cap_latch: assert property (cap_event |=> duty_reg == $past(count_reg)) // [R5]
        else $error("capture value not latched");
    a_pwm_full: assert property (m_pwm && ctrl_reg.output_action == PTM_IO_10 &&
        period_reg != 10'h000 && duty_reg >= period_reg && on_reg
        |=> pin_out_reg == ($past(act) ^ $past(ctrl_reg.polarity_invert_bit))) // [R22]
        else $error("pwm not at full duty");
endmodule : ptm_timer
`default_nettype wire

// *** pkg/ptm_pkg.sv ***
package ptm_pkg;
    localparam int PTM_CW = 10;
    localparam int PTM_AW = 8;
    // byte addresses of the register words
    localparam logic [7:0] PTM_OFS_CTRL0 = 8'h00;
    localparam logic [7:0] PTM_OFS_CTRL1 = 8'h04;
    localparam logic [7:0] PTM_OFS_COUNT = 8'h08;
    localparam logic [7:0] PTM_OFS_DUTY = 8'h0c;
    localparam logic [7:0] PTM_OFS_PERIOD = 8'h10;
    localparam logic [7:0] PTM_OFS_FLAGS = 8'h14;
    // field positions
    localparam int PTM_POS_ON = 3;
    localparam int PTM_POS_DUTY_FLAG = 0;
    localparam int PTM_POS_PERIOD_FLAG = 1;
    // reset values
    localparam logic [7:0] PTM_RST_CTRL1 = 8'h00;
    localparam logic [9:0] PTM_RST_CMP = 10'h000;
    // mode select codes
    localparam logic [1:0] PTM_MODE_CMP = 2'h0;
    localparam logic [1:0] PTM_MODE_CAP = 2'h1;
    localparam logic [1:0] PTM_MODE_PWM = 2'h2;
    localparam logic [1:0] PTM_MODE_TMR = 2'h3;
    // output action codes
    localparam logic [1:0] PTM_IO_00 = 2'h0;
    localparam logic [1:0] PTM_IO_01 = 2'h1;
    localparam logic [1:0] PTM_IO_10 = 2'h2;
    localparam logic [1:0] PTM_IO_11 = 2'h3;
    localparam logic [1:0] PTM_RESP_OKAY = 2'h0;
    localparam logic [1:0] PTM_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] mode_select;
        logic [1:0] output_action;
        logic initial_level_bit;
        logic polarity_invert_bit;
        logic capture_source_bit;
        logic clear_select_bit;
    } ptm_ctrl_t;
endpackage : ptm_pkg

// *** verif/ptm_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ptm_pin_model (
    // design side of the pins
    input wire logic pin_out_in,
    input wire logic pin_oe_in,
    output logic pin_level_out,
    output logic clock_pin_out,
    // far-side stimulus from the bench
    input wire logic stim_level_in,
    input wire logic stim_clock_in
);
    // no pull: released, the pin shows the far side
    assign pin_level_out = pin_oe_in ? pin_out_in : stim_level_in;
    // idle unless pulsed
    assign clock_pin_out = stim_clock_in;
endmodule : ptm_pin_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ptm_pkg::*;
    localparam int CEIL = 60000;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic stim_lvl = 1'b0;
    logic stim_clk = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, pin_lvl, clk_pin;
    logic duty_flag, period_flag, cnt_on;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    ptm_timer uut (.clk_in(clk), .arst_n_in(arst_n),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .timer_output_pin_in(pin_lvl),
        .timer_output_pin_out(pin_out), .timer_output_pin_oe_out(pin_oe),
        .timer_clock_pin_in(clk_pin), .duty_match_flag_out(duty_flag),
        .period_match_flag_out(period_flag), .counter_on_out(cnt_on));
    ptm_pin_model pins (.pin_out_in(pin_out), .pin_oe_in(pin_oe), .pin_level_out(pin_lvl),
        .clock_pin_out(clk_pin), .stim_level_in(stim_lvl), .stim_clock_in(stim_clk));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask : rd
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, PTM_RESP_OKAY, d);
        chk(what, d, exp);
    endtask : rchk
    function automatic logic [7:0] c1(input logic [1:0] m, input logic [1:0] a,
        input logic i, input logic p, input logic s, input logic c);
        return {m, a, i, p, s, c};
    endfunction : c1
    // settings only change while the counter is off
    task automatic cfg(input logic [7:0] c, input logic [9:0] d, input logic [9:0] p);
        wr(PTM_OFS_CTRL0, 32'h0, PTM_RESP_OKAY);
        wr(PTM_OFS_CTRL1, {24'h0, c}, PTM_RESP_OKAY);
        wr(PTM_OFS_DUTY, {22'h0, d}, PTM_RESP_OKAY);
        wr(PTM_OFS_PERIOD, {22'h0, p}, PTM_RESP_OKAY);
        wr(PTM_OFS_FLAGS, 32'h3, PTM_RESP_OKAY);
        wr(PTM_OFS_CTRL0, 32'h8, PTM_RESP_OKAY);
    endtask : cfg
    // cycles the pin stands at lvl after a fresh change
    task automatic meas(input logic lvl, output int n);
        int k;
        n = 0;
        k = 0;
        @(negedge clk);
        while (pin_out !== ~lvl && k < 3000) begin
            @(negedge clk);
            k++;
        end
        while (pin_out !== lvl && k < 6000) begin
            @(negedge clk);
            k++;
        end
        while (pin_out === lvl && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask : meas
    task automatic t_reset();
        logic [31:0] d;
        rchk("ctrl1", PTM_OFS_CTRL1, {24'h0, PTM_RST_CTRL1});
        rchk("duty", PTM_OFS_DUTY, {22'h0, PTM_RST_CMP});
        rchk("period", PTM_OFS_PERIOD, {22'h0, PTM_RST_CMP});
        rchk("count", PTM_OFS_COUNT, 32'h0);
        wr(PTM_OFS_DUTY, 32'hffff_ffff, PTM_RESP_OKAY);
        rchk("duty width", PTM_OFS_DUTY, 32'h3ff);
        wr(8'h3c, 32'h1, PTM_RESP_SLVERR);
        rd(8'h3c, PTM_RESP_SLVERR, d);
        chk("unmapped data", d, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic cmp_toggle(input logic clr, input logic [9:0] d, input logic [9:0] p,
        input int e);
        int n;
        cfg(c1(PTM_MODE_CMP, PTM_IO_11, 1'b0, 1'b0, 1'b0, clr), d, p);
        meas(1'b1, n);
        chk("toggle high", n, e);
        meas(1'b0, n);
        chk("toggle low", n, e);
        chk("cmp oe", pin_oe, 1'b1);
        rchk("cmp flags", PTM_OFS_FLAGS, clr ? 32'h1 : 32'h3);
    endtask : cmp_toggle
    task automatic cmp_level(input logic [1:0] a, input logic i, input logic p,
        input logic s, input logic e);
        cfg(c1(PTM_MODE_CMP, a, i, p, 1'b0, 1'b0), 10'd20, 10'd50);
        repeat (4) @(negedge clk);
        chk("start level", pin_out, s);
        repeat (60) @(negedge clk);
        chk("after match", pin_out, e);
        wr(PTM_OFS_CTRL0, 32'h0, PTM_RESP_OKAY);
        wr(PTM_OFS_CTRL0, 32'h8, PTM_RESP_OKAY);
        repeat (4) @(negedge clk);
        chk("restart level", pin_out, s);
    endtask : cmp_level
    task automatic t_compare();
        cmp_toggle(1'b1, 10'd6, 10'd3, 6);
        cmp_toggle(1'b0, 10'd4, 10'd9, 9);
        cmp_toggle(1'b0, 10'd4, 10'd0, 1024);
        cmp_level(PTM_IO_01, 1'b1, 1'b0, 1'b1, 1'b0);
        cmp_level(PTM_IO_10, 1'b0, 1'b0, 1'b0, 1'b1);
        cmp_level(PTM_IO_00, 1'b1, 1'b0, 1'b1, 1'b1);
        cmp_level(PTM_IO_10, 1'b0, 1'b1, 1'b1, 1'b0);
        $display("test compare done");
    endtask : t_compare
    task automatic pwm_case(input logic i, input logic p, input logic c, input logic [9:0] d,
        input logic [9:0] q, input int eh, input int el);
        int n;
        cfg(c1(PTM_MODE_PWM, PTM_IO_10, i, p, 1'b0, c), d, q);
        meas(1'b1, n);
        chk("pwm high", n, eh);
        meas(1'b0, n);
        chk("pwm low", n, el);
        rchk("pwm flags", PTM_OFS_FLAGS, 32'h3);
    endtask : pwm_case
    task automatic pwm_fixed(input logic [1:0] a, input logic [9:0] d, input logic e);
        int k;
        cfg(c1(PTM_MODE_PWM, a, 1'b1, 1'b0, 1'b0, 1'b0), d, 10'd10);
        k = 0;
        repeat (40) begin
            @(negedge clk);
            if (pin_out !== e) k++;
        end
        chk("pwm fixed level", k, 0);
        rchk("pwm fixed flags", PTM_OFS_FLAGS, {31'h1, d <= 10'd10});
    endtask : pwm_fixed
    task automatic t_pwm();
        pwm_case(1'b1, 1'b0, 1'b0, 10'd3, 10'd10, 3, 7);
        pwm_case(1'b0, 1'b0, 1'b1, 10'd3, 10'd10, 7, 3);
        pwm_case(1'b1, 1'b1, 1'b1, 10'd3, 10'd10, 7, 3);
        pwm_case(1'b1, 1'b0, 1'b0, 10'd24, 10'd0, 24, 1000);
        pwm_fixed(PTM_IO_10, 10'd12, 1'b1);
        pwm_fixed(PTM_IO_00, 10'd3, 1'b0);
        pwm_fixed(PTM_IO_01, 10'd3, 1'b1);
        $display("test pwm done");
    endtask : t_pwm
    task automatic t_timer();
        logic [31:0] a;
        logic [31:0] b;
        cfg(c1(PTM_MODE_TMR, PTM_IO_10, 1'b1, 1'b1, 1'b0, 1'b0), 10'd1000, 10'd0);
        repeat (1100) @(negedge clk);
        chk("timer oe", pin_oe, 1'b0);
        rchk("timer flags", PTM_OFS_FLAGS, 32'h3);
        wr(PTM_OFS_CTRL0, 32'h0, PTM_RESP_OKAY);
        rd(PTM_OFS_COUNT, PTM_RESP_OKAY, a);
        repeat (20) @(negedge clk);
        rd(PTM_OFS_COUNT, PTM_RESP_OKAY, b);
        chk("count held", b, a);
        wr(PTM_OFS_CTRL0, 32'h8, PTM_RESP_OKAY);
        rd(PTM_OFS_COUNT, PTM_RESP_OKAY, b);
        chk("count restarted", b < 32'd12, 1'b1);
        $display("test timer done");
    endtask : t_timer
    // waits cover the pin synchroniser
    task automatic t_capture();
        for (int a = 0; a < 4; a++) begin
            cfg(c1(PTM_MODE_CAP, a[1:0], 1'b0, 1'b0, 1'b0, 1'b0), 10'd0, 10'd0);
            @(posedge clk) stim_lvl <= 1'b1;
            repeat (12) @(negedge clk);
            chk("capture oe", pin_oe, 1'b0);
            rchk("rise capture", PTM_OFS_FLAGS, (a == 0 || a == 2) ? 32'h1 : 32'h0);
            wr(PTM_OFS_FLAGS, 32'h3, PTM_RESP_OKAY);
            @(posedge clk) stim_lvl <= 1'b0;
            repeat (12) @(negedge clk);
            rchk("fall capture", PTM_OFS_FLAGS, (a == 1 || a == 2) ? 32'h1 : 32'h0);
        end
        cfg(c1(PTM_MODE_CAP, PTM_IO_00, 1'b0, 1'b0, 1'b1, 1'b0), 10'd0, 10'd0);
        @(posedge clk) stim_lvl <= 1'b1;
        repeat (12) @(negedge clk);
        rchk("output pin ignored", PTM_OFS_FLAGS, 32'h0);
        @(posedge clk) stim_clk <= 1'b1;
        repeat (12) @(negedge clk);
        rchk("clock pin capture", PTM_OFS_FLAGS, 32'h1);
        @(posedge clk) stim_clk <= 1'b0;
        $display("test capture done");
    endtask : t_capture
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_compare();
        t_pwm();
        t_timer();
        t_capture();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
